// file: pkg/serdes_rx_consts.svh
`ifndef SERDES_RX_CONSTS_SVH
`define SERDES_RX_CONSTS_SVH

// ****************************************************************
// clock and line timing
// ****************************************************************
`define CLK_MHZ            40
`define BIT_CYCLES         2'h3
`define BIT_SAMPLE_PHASE   2'h2
`define REF_TIMEOUT_NS     1000
`define REF_TIMEOUT_CYCLES (((`REF_TIMEOUT_NS) * (`CLK_MHZ)) / 1000)
`define REF_CNT_W          8

// ****************************************************************
// word framing
// ****************************************************************
`define WORD_BITS          12
`define DATA_BITS          10
`define FRAME_START_POS    11
`define FRAME_STOP_POS     0
`define WORD_LAST_BIT      4'hb
`define RCLK_HIGH_BITS     4'h6

// ****************************************************************
// lock detection
// ****************************************************************
`define LOSS_WORDS         3'h4
`define RANDOM_LOCK_WORDS  4'h8

// ****************************************************************
// synchronised pin positions
// ****************************************************************
`define PIN_COUNT          6
`define PIN_POS            0
`define PIN_NEG            1
`define PIN_REF            2
`define PIN_SLEEP_N        3
`define PIN_OE             4
`define PIN_EDGE_SEL       5

`endif

// file: pkg/serdes_rx_pkg.sv
`default_nettype none

package serdes_rx_pkg;

  // ****************************************************************
  // lock state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b001,
    ST_HUNT   = 3'b010,
    ST_LOCKED = 3'b100
  } lock_state_t;

endpackage : serdes_rx_pkg

`default_nettype wire

// file: src/word_framer.sv
`include "serdes_rx_consts.svh"
`default_nettype none

module word_framer (
  input  wire logic [`WORD_BITS-1:0] frame,
  output logic                       frame_ok,
  output logic                       sync_seen,
  output logic [`DATA_BITS-1:0]      word
);

  // ****************************************************************
  // sync pattern: one run of ones from bit 0 then zeros to bit 9
  // ****************************************************************
  function automatic logic is_step(input logic [`DATA_BITS-1:0] w);
    logic ok;
    ok = w[0] & ~w[`DATA_BITS-1];
    for (int i = 0; i < `DATA_BITS - 1; i++) begin
      if (!w[i] && w[i+1]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_step

  // oldest bit sits at the top, so data bit 0 follows the start bit
  genvar g;
  generate
    for (g = 0; g < `DATA_BITS; g++) begin : g_unpack
      assign word[g] = frame[`FRAME_START_POS-1-g];
    end
  endgenerate

  // high clock bit, ten data bits, low clock bit
  assign frame_ok  = frame[`FRAME_START_POS] & ~frame[`FRAME_STOP_POS];
  assign sync_seen = frame_ok & is_step(word);

endmodule : word_framer

`default_nettype wire

// file: src/serial_link_deserializer_lock.sv
`include "serdes_rx_consts.svh"
`default_nettype none

module serial_link_deserializer_lock (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  serial_in_pos,
  input  wire logic                  serial_in_neg,
  input  wire logic                  local_reference_clock,
  input  wire logic                  sleep_n,
  input  wire logic                  output_enable,
  input  wire logic                  strobe_edge_select,
  output logic [`DATA_BITS-1:0]      word_out,
  output logic                       word_out_oe,
  output logic                       recovered_clock,
  output logic                       recovered_clock_oe,
  output logic                       unlocked,
  output logic                       unlocked_oe
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire  [`PIN_COUNT-1:0] pin_raw;
  wire  [`PIN_COUNT-1:0] pin_f;

  assign pin_raw = {strobe_edge_select, output_enable, sleep_n,
                    local_reference_clock, serial_in_neg, serial_in_pos};

  // a change is taken only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      logic f;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          f  <= 1'b0;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            f <= s3;
          end
        end
      end
      assign pin_f[g] = f;
    end
  endgenerate

  logic awake;
  logic out_en;
  logic rise_sel;

  assign awake    = pin_f[`PIN_SLEEP_N];
  assign out_en   = pin_f[`PIN_OE];
  assign rise_sel = pin_f[`PIN_EDGE_SEL];

  // ****************************************************************
  // reference clock activity
  // ****************************************************************
  logic                  ref_prev;
  logic [`REF_CNT_W-1:0] ref_idle;
  logic                  ref_alive;

  // a stalled reference would let the loop free-run onto noise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_prev <= 1'b0;
      ref_idle <= '0;
    end else begin
      ref_prev <= pin_f[`PIN_REF];
      if (ref_prev != pin_f[`PIN_REF]) begin
        ref_idle <= '0;
      end else if (ref_idle != `REF_CNT_W'(`REF_TIMEOUT_CYCLES)) begin
        ref_idle <= ref_idle + `REF_CNT_W'(1);
      end
    end
  end

  assign ref_alive = (ref_idle != `REF_CNT_W'(`REF_TIMEOUT_CYCLES));

  // ****************************************************************
  // bit recovery loop
  // ****************************************************************
  serdes_rx_pkg::lock_state_t state;
  serdes_rx_pkg::lock_state_t next_state;

  logic                  line_bit;
  logic                  line_prev;
  logic [1:0]            phase;
  logic                  bit_done;
  logic [`WORD_BITS-1:0] shreg;

  // equal legs carry no information, so the last bit is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_bit <= 1'b0;
    end else if (pin_f[`PIN_POS] != pin_f[`PIN_NEG]) begin
      line_bit <= pin_f[`PIN_POS];
    end
  end

  // each line edge recentres the sampling phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_prev <= 1'b0;
      phase     <= 2'h0;
      bit_done  <= 1'b0;
      shreg     <= '0;
    end else if (state == serdes_rx_pkg::ST_SLEEP) begin
      line_prev <= line_bit;
      phase     <= 2'h0;
      bit_done  <= 1'b0;
    end else begin
      line_prev <= line_bit;
      if (line_bit != line_prev || phase == `BIT_CYCLES) begin
        phase <= 2'h0;
      end else begin
        phase <= phase + 2'h1;
      end
      bit_done <= (phase == `BIT_SAMPLE_PHASE);
      if (phase == `BIT_SAMPLE_PHASE) begin
        shreg <= {shreg[`WORD_BITS-2:0], line_bit};
      end
    end
  end

  logic                  frame_ok;
  logic                  sync_seen;
  logic [`DATA_BITS-1:0] frame_word;

  word_framer u_framer (
    .frame     (shreg),
    .frame_ok  (frame_ok),
    .sync_seen (sync_seen),
    .word      (frame_word)
  );

  // ****************************************************************
  // lock state machine
  // ****************************************************************
  logic [3:0] bitcnt;
  logic [3:0] good_cnt;
  logic [2:0] bad_cnt;
  logic [3:0] next_bitcnt;
  logic [3:0] next_good_cnt;
  logic [2:0] next_bad_cnt;
  logic       word_end;

  always_comb begin
    next_state    = state;
    next_bitcnt   = bitcnt;
    next_good_cnt = good_cnt;
    next_bad_cnt  = bad_cnt;
    word_end      = 1'b0;
    case (state)
      serdes_rx_pkg::ST_SLEEP: begin
        next_bitcnt   = 4'h0;
        next_good_cnt = 4'h0;
        next_bad_cnt  = 3'h0;
        next_state    = serdes_rx_pkg::ST_HUNT;
      end
      serdes_rx_pkg::ST_HUNT: begin
        if (bit_done) begin
          if (!ref_alive) begin
            next_good_cnt = 4'h0;
          end else if (good_cnt == 4'h0 || bitcnt == `WORD_LAST_BIT) begin
            next_bitcnt = 4'h0;
            if (!frame_ok) begin
              next_good_cnt = 4'h0;
            end else if (sync_seen ||
                         good_cnt == `RANDOM_LOCK_WORDS - 4'h1) begin
              // sync pattern locks at once, random data after a run
              next_state    = serdes_rx_pkg::ST_LOCKED;
              next_good_cnt = 4'h0;
              next_bad_cnt  = 3'h0;
            end else begin
              next_good_cnt = good_cnt + 4'h1;
            end
          end else begin
            next_bitcnt = bitcnt + 4'h1;
          end
        end
      end
      serdes_rx_pkg::ST_LOCKED: begin
        if (!ref_alive) begin
          next_state = serdes_rx_pkg::ST_HUNT;
        end else if (bit_done) begin
          if (bitcnt == `WORD_LAST_BIT) begin
            next_bitcnt = 4'h0;
            word_end    = 1'b1;
            if (frame_ok) begin
              next_bad_cnt = 3'h0;
            end else if (bad_cnt == `LOSS_WORDS - 3'h1) begin
              next_state   = serdes_rx_pkg::ST_HUNT;
              next_bad_cnt = 3'h0;
            end else begin
              next_bad_cnt = bad_cnt + 3'h1;
            end
          end else begin
            next_bitcnt = bitcnt + 4'h1;
          end
        end
      end
      default: begin
        next_state = serdes_rx_pkg::ST_SLEEP;
      end
    endcase
    if (!awake) begin
      next_state = serdes_rx_pkg::ST_SLEEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= serdes_rx_pkg::ST_SLEEP;
      bitcnt   <= 4'h0;
      good_cnt <= 4'h0;
      bad_cnt  <= 3'h0;
    end else begin
      state    <= next_state;
      bitcnt   <= next_bitcnt;
      good_cnt <= next_good_cnt;
      bad_cnt  <= next_bad_cnt;
    end
  end

  // ****************************************************************
  // parallel word and recovered clock
  // ****************************************************************
  logic                  next_locked;
  logic                  next_rclk;
  logic [`DATA_BITS-1:0] held_word;

  assign next_locked = (next_state == serdes_rx_pkg::ST_LOCKED);
  // high for the first half of each word, so one cycle per word
  assign next_rclk   = next_locked && (next_bitcnt < `RCLK_HIGH_BITS);

  // words during the first three bad ones still pass; they may be corrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_word <= '0;
    end else if (word_end) begin
      held_word <= frame_word;
    end
  end

  // data changes on the inactive edge so it is stable at the active one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_out <= '0;
    end else if (!rise_sel && word_end) begin
      word_out <= frame_word;
    end else if (rise_sel && recovered_clock && !next_rclk &&
                 next_locked) begin
      word_out <= held_word;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recovered_clock <= 1'b0;
    end else begin
      recovered_clock <= next_rclk;
    end
  end

  // ****************************************************************
  // output drive and lock indicator
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlocked    <= 1'b1;
      unlocked_oe <= 1'b0;
    end else begin
      unlocked    <= !next_locked;
      unlocked_oe <= awake;
    end
  end

  // floating until locked also covers the power-up case
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_out_oe        <= 1'b0;
      recovered_clock_oe <= 1'b0;
    end else begin
      word_out_oe        <= awake && out_en && next_locked;
      recovered_clock_oe <= awake && out_en && next_locked;
    end
  end

endmodule : serial_link_deserializer_lock

`default_nettype wire

// file: testbench/serial_link_deserializer_lock_monitor.sv
`include "serdes_rx_consts.svh"
`default_nettype none

module serial_link_deserializer_lock_monitor (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  serial_in_pos,
  input wire logic                  serial_in_neg,
  input wire logic                  local_reference_clock,
  input wire logic                  sleep_n,
  input wire logic                  output_enable,
  input wire logic                  strobe_edge_select,
  input wire logic [`DATA_BITS-1:0] word_out,
  input wire logic                  word_out_oe,
  input wire logic                  recovered_clock,
  input wire logic                  recovered_clock_oe,
  input wire logic                  unlocked,
  input wire logic                  unlocked_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // checks
  // ********
  logic live;
  assign live = unlocked_oe && !unlocked;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_sleep_floats: assert property (!sleep_n [*8] |-> !word_out_oe &&
    !recovered_clock_oe && !unlocked_oe) else $error("driven while asleep");
  a_enable_floats: assert property (!output_enable [*8] |->
    !word_out_oe && !recovered_clock_oe) else $error("driven while disabled");
  a_flag_driven: assert property (sleep_n [*8] |-> unlocked_oe)
    else $error("lock flag not driven");
  a_unlock_floats: assert property (unlocked |-> !word_out_oe &&
    !recovered_clock_oe) else $error("driven while unlocked");
  a_oe_needs_lock: assert property (word_out_oe |-> recovered_clock_oe &&
    live) else $error("outputs driven without lock");
  a_wake_hunts: assert property ($rose(unlocked_oe) |-> unlocked)
    else $error("locked straight out of sleep");
  a_clock_shape: assert property ($rose(recovered_clock) && live |->
    ##23 (!live || recovered_clock) ##1 (!live || !recovered_clock))
    else $error("recovered clock high time wrong");
  a_word_spacing: assert property ($rose(recovered_clock) && live |->
    ##48 (!live || $rose(recovered_clock))) else $error("word period wrong");
  a_strobe_edge: assert property ($changed(word_out) && word_out_oe &&
    $past(word_out_oe) |-> (strobe_edge_select ? $fell(recovered_clock)
    : $rose(recovered_clock))) else $error("data on wrong clock edge");
endmodule : serial_link_deserializer_lock_monitor

bind serial_link_deserializer_lock serial_link_deserializer_lock_monitor
  i_serial_link_deserializer_lock_monitor (.clk(clk), .rst(rst),
  .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg),
  .local_reference_clock(local_reference_clock), .sleep_n(sleep_n),
  .output_enable(output_enable), .strobe_edge_select(strobe_edge_select),
  .word_out(word_out), .word_out_oe(word_out_oe),
  .recovered_clock(recovered_clock), .recovered_clock_oe(recovered_clock_oe),
  .unlocked(unlocked), .unlocked_oe(unlocked_oe));

`default_nettype wire

// file: testbench/serializer_model.sv
`default_nettype none

module serializer_model #(
  parameter int MIN_SYNC_WORDS = 1024
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [9:0] data_in,
  input  wire logic       pattern_request_a,
  input  wire logic       pattern_request_b,
  input  wire logic       bad_clock,
  output logic            serial_in_pos,
  output logic            serial_in_neg,
  output logic            word_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // line framing, four clk cycles per bit
  // ********
  logic [5:0]  cnt;
  logic [11:0] frame;
  logic [10:0] sync_left;
  logic        req;
  assign req = pattern_request_a | pattern_request_b;
  assign word_tick = (cnt == 6'h2f);
  assign serial_in_pos = frame[cnt[5:2]];
  assign serial_in_neg = ~serial_in_pos;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
      frame <= 12'h001;
      sync_left <= 11'h000;
    end else begin
      cnt <= word_tick ? 6'h00 : cnt + 6'h01;
      if (word_tick) begin
        // bad words swap both clock bits so the stream still toggles
        frame <= {bad_clock, (req || sync_left != 11'h000) ? 10'h01f
                  : data_in, ~bad_clock};
        if (req) begin
          sync_left <= 11'(MIN_SYNC_WORDS);
        end else if (sync_left != 11'h000) begin
          sync_left <= sync_left - 11'h001;
        end
      end
    end
  end
endmodule : serializer_model

`default_nettype wire

// file: testbench/serial_link_deserializer_lock_bench.sv
`default_nettype none

module serial_link_deserializer_lock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, ref_run, sleep_n, output_enable, edge_sel;
  logic       ref_clk = 1'b0;
  logic [1:0] ref_div = 2'h0;
  logic       fb_en, bad_clock, pos, neg, tick, seen_unlock, req_a;
  logic       wo_oe, rc, rc_oe, unlocked, un_oe;
  logic [9:0] data_in, word_out;
  int         error_cnt, n_tests, cycles;
  assign req_a = fb_en & unlocked;
  serial_link_deserializer_lock i_serial_link_deserializer_lock (
    .clk(clk), .rst(rst), .serial_in_pos(pos), .serial_in_neg(neg),
    .local_reference_clock(ref_clk), .sleep_n(sleep_n),
    .output_enable(output_enable), .strobe_edge_select(edge_sel),
    .word_out(word_out), .word_out_oe(wo_oe), .recovered_clock(rc),
    .recovered_clock_oe(rc_oe), .unlocked(unlocked), .unlocked_oe(un_oe));
  serializer_model #(.MIN_SYNC_WORDS(4)) i_serializer_model (
    .clk(clk), .rst(rst), .data_in(data_in), .pattern_request_a(req_a),
    .pattern_request_b(1'b0), .bad_clock(bad_clock),
    .serial_in_pos(pos), .serial_in_neg(neg), .word_tick(tick));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // reference toggles every four cycles so the pin filter can follow it
  always @(posedge clk) begin
    ref_div <= ref_div + 2'h1;
    if (ref_run && ref_div == 2'h0) begin
      ref_clk <= ~ref_clk;
    end
  end
  // ********
  // helpers
  // ********
  task automatic chk(input string what, input logic [9:0] exp,
                     input logic [9:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic words(input int n);
    repeat (n) begin
      do begin
        @(posedge clk);
        seen_unlock = seen_unlock | unlocked;
      end while (!tick);
    end
  endtask : words
  task automatic wait_lock(input int bound);
    int i;
    for (i = 0; i < bound && unlocked !== 1'b0; i++) begin
      @(posedge clk);
    end
    @(posedge clk);
    chk("lock flag", 10'h0, 10'(unlocked));
    chk("clock oe", 10'h1, 10'(rc_oe));
  endtask : wait_lock
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ********
  // scenarios
  // ********
  task automatic t_sleep;
    sleep_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("data oe asleep", 10'h0, 10'(wo_oe));
    chk("clock oe asleep", 10'h0, 10'(rc_oe));
    chk("flag oe asleep", 10'h0, 10'(un_oe));
  endtask : t_sleep
  task automatic t_data;
    logic [9:0] tbl [5];
    tbl = '{10'h001, 10'h200, 10'h2a5, 10'h000, 10'h3ff};
    words(6);
    foreach (tbl[i]) begin
      data_in <= tbl[i];
      words(3);
      chk("word out", tbl[i], word_out);
    end
  endtask : t_data
  task automatic t_enable;
    output_enable <= 1'b0;
    repeat (10) @(posedge clk);
    chk("data oe off", 10'h0, 10'(wo_oe));
    chk("clock oe off", 10'h0, 10'(rc_oe));
    chk("flag oe on", 10'h1, 10'(un_oe));
    chk("still locked", 10'h0, 10'(unlocked));
    output_enable <= 1'b1;
    repeat (10) @(posedge clk);
    chk("clock oe back", 10'h1, 10'(rc_oe));
  endtask : t_enable
  task automatic t_loss;
    seen_unlock = 1'b0;
    words(1);
    bad_clock <= 1'b1;
    words(3);
    bad_clock <= 1'b0;
    words(3);
    chk("held on 3 bad", 10'h0, 10'(seen_unlock));
    bad_clock <= 1'b1;
    words(5);
    // the fourth bad word is still crossing the pin filter here
    repeat (12) @(posedge clk);
    chk("lost on 4 bad", 10'h1, 10'(unlocked));
    chk("data oe lost", 10'h0, 10'(wo_oe));
    bad_clock <= 1'b0;
    wait_lock(3000);
    // words around the relock are skipped as suspect before comparing
    t_data();
  endtask : t_loss
  task automatic t_ref_idle;
    ref_run <= 1'b0;
    repeat (80) @(posedge clk);
    chk("no lock idle ref", 10'h1, 10'(unlocked));
    ref_run <= 1'b1;
    wait_lock(3000);
  endtask : t_ref_idle
  task automatic t_random_lock;
    t_sleep();
    chk("flag asleep", 10'h1, 10'(unlocked));
    fb_en <= 1'b0;
    edge_sel <= 1'b1;
    data_in <= 10'h3ff;
    words(6);
    sleep_n <= 1'b1;
    wait_lock(4000);
    t_data();
  endtask : t_random_lock
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    ref_run = 1'b1;
    sleep_n = 1'b0;
    output_enable = 1'b1;
    edge_sel = 1'b0;
    fb_en = 1'b1;
    bad_clock = 1'b0;
    data_in = 10'h2a5;
    seen_unlock = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_sleep();
    sleep_n <= 1'b1;
    wait_lock(3000);
    t_data();
    t_enable();
    t_loss();
    t_ref_idle();
    t_random_lock();
    report_and_stop();
  end
endmodule : serial_link_deserializer_lock_bench

`default_nettype wire
